// *** common/fpp_pkg.sv ***
// package: constants and types of the flash program and protection controller
package fpp_pkg;
  // register word indices (byte address is four times the index)
  localparam logic [3:0] OFS_KEY   = 4'h0;
  localparam logic [3:0] OFS_OBKEY = 4'h1;
  localparam logic [3:0] OFS_STS   = 4'h2;
  localparam logic [3:0] OFS_CTRL1 = 4'h3;
  localparam logic [3:0] OFS_CTRL2 = 4'h4;
  localparam logic [3:0] OFS_ADDR  = 4'h5;
  localparam logic [3:0] OFS_DATA  = 4'h6;
  localparam logic [3:0] OFS_OBCS  = 4'h7;
  localparam logic [3:0] OFS_WPROT = 4'h8;
  // status bits
  localparam int STS_BUSY = 0;
  localparam int STS_PEF  = 2;
  localparam int STS_WRPROT_ERROR_FLAG = 4;
  localparam int STS_OCF  = 5;
  localparam int STS_OBE  = 6;
  // primary control bits
  localparam int C1_PG   = 0;
  localparam int C1_PER  = 1;
  localparam int C1_MER  = 2;
  localparam int C1_OPG  = 4;
  localparam int C1_OER  = 5;
  localparam int C1_STRT = 6;
  localparam logic [6:0] C1_RST = 7'h00;
  // secondary control bits
  localparam int C2_LOCK  = 0;
  localparam int C2_OPTION_WRITE_ENABLE = 1;
  localparam int C2_OP_COMPLETE_IRQ_EN  = 2;
  // keys, levels and array values
  localparam logic [31:0] UNLOCK_KEY_FIRST  = 32'h45670123;
  localparam logic [31:0] UNLOCK_KEY_SECOND = 32'hcdef89ab;
  localparam logic [7:0]  RP_LEVEL0 = 8'haa;
  localparam logic [7:0]  RP_LEVEL2 = 8'hcc;
  localparam logic [7:0]  OPT_BAD   = 8'hff;
  localparam logic [15:0] ERASED_HW = 16'hffff;
  localparam logic [63:0] OPT_RST   = 64'hffffffffffffffff;
  localparam logic [2:0]  OPT_LAST  = 3'h7;
  localparam int UNIT_LSB = 12;

  typedef enum logic [1:0] {KEY_IDLE = 2'b00, KEY_HALF = 2'b01, KEY_OPEN = 2'b10, KEY_DEAD = 2'b11} fpp_key_t;
  typedef enum logic [1:0] {MODE_USER = 2'b00, MODE_DEBUG = 2'b01, MODE_SRAM = 2'b10, MODE_SYSMEM = 2'b11} fpp_mode_t;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000, OP_READ = 3'b001, OP_PROG = 3'b010, OP_PAGE_ERASE = 3'b011,
    OP_MASS_ERASE = 3'b100, OP_OPT_READ = 3'b101, OP_OPT_PROG = 3'b110, OP_OPT_ERASE = 3'b111
  } fpp_op_t;
  typedef enum logic [2:0] {
    ST_LOAD = 3'b000, ST_LOADW = 3'b001, ST_IDLE = 3'b010, ST_CHECK = 3'b011, ST_EXEC = 3'b100, ST_PRE = 3'b101
  } fpp_state_t;
  typedef struct packed {
    fpp_op_t     op;
    logic [15:0] addr;
    logic [15:0] data;
  } fpp_flash_req_t;

  // one step of the two-key unlock sequence
  function automatic fpp_key_t fpp_key_step(input fpp_key_t cur, input logic [31:0] wd);
    unique case (cur)
      KEY_IDLE: fpp_key_step = (wd == UNLOCK_KEY_FIRST) ? KEY_HALF : KEY_DEAD;
      KEY_HALF: fpp_key_step = (wd == UNLOCK_KEY_SECOND) ? KEY_OPEN : KEY_DEAD;
      KEY_OPEN: fpp_key_step = KEY_DEAD;
      KEY_DEAD: fpp_key_step = KEY_DEAD;
    endcase
  endfunction : fpp_key_step
endpackage : fpp_pkg

// *** design/fpp_flash_ctrl.sv ***
// flash program, erase, protection and option reload controller
//
// What this block does
// - a mass erase command erases the whole main area at once
// - main area programming takes one 16-bit half-word per write
// - programming a non-erased location discards data and sets program error flag
// - writing a write-protected location discards data and sets protection error flag
// - write protection works in units of four 1KB pages, one option bit each
// - level 0 (0xaa) allows erase, write, read of main area and option bytes
// - level 1 allows all in user mode; other modes block main area only
// - changing level 1 to level 0 first mass erases the main area
// - level 2 (0xcc) denies debug, all main access and option program and erase, level fixed
// - protected pages are not modified by program, page erase or mass erase command; a level 1 to level 0 change erases them
// - after reset the primary control register is locked, direct writes ignored
// - unlock needs first key then second key, in that order
// - a wrong key or order locks until the next reset: everything on the key register, option work only on the option key register
// - writing one to the lock bit relocks the controller
// - finished option erase or write sets complete flag, interrupt if enabled
// - option work needs the two keys on the option key register, shows enable
// - clearing option write enable blocks further option program and erase
// - option bytes lock at every reset; software locks them by clearing option write enable
// - reset reloads option bytes into status registers; only reload applies them
// - the option area holds eight bytes, each with a complement byte
// - a byte not matching its complement sets option error and reads 0xff
// - finished page erase or main write sets complete flag, interrupt if enabled
// - only 0xffff counts as erased; anything else gives a program error
`timescale 1ns/1ns
module fpp_flash_ctrl
  import fpp_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           rst_n,
  input  wire logic [3:0]     avs_address,
  input  wire logic           avs_read,
  input  wire logic           avs_write,
  input  wire logic [31:0]    avs_writedata,
  input  wire logic [3:0]     avs_byteenable,
  output logic      [31:0]    avs_readdata,
  output logic                avs_waitrequest,
  input  wire fpp_mode_t      cpuMode,
  output fpp_flash_req_t      flashReq,
  output logic                flashReqValid,
  input  wire logic           flashAck,
  input  wire logic [15:0]    flashRdata,
  output logic                opCompleteIrq,
  output logic                mainAccessEn,
  output logic                debugDeny
);
  fpp_state_t     state_r, state_nxt;
  fpp_key_t       mainKey_r, mainKey_nxt;
  fpp_key_t       optKey_r, optKey_nxt;
  fpp_flash_req_t req_r, req_nxt;
  logic           reqV_r, reqV_nxt;
  logic [15:0]    pend_r, pend_nxt;
  logic [2:0]     idx_r, idx_nxt;
  logic [63:0]    opt_r;
  logic [6:0]     ctrl1_r;
  logic           op_complete_irq_en_r;
  logic [15:0]    addr_r;
  logic           pef_r, wrprot_error_flag_r, ocf_r, obe_r;
  logic           rdDone_r;
  logic [31:0]    rdata_r;
  logic           setPef, setWpef, setOcf, setObe, optLoad;

  // bus decode
  wire        loading  = (state_r == ST_LOAD) || (state_r == ST_LOADW);
  wire        idle     = (state_r == ST_IDLE);
  wire        wrEn     = avs_write && !loading;
  wire        fullWord = (avs_byteenable == 4'hf);
  wire [31:0] wd       = avs_writedata;
  wire        hitKey   = wrEn && fullWord && (avs_address == OFS_KEY);
  wire        hitObkey = wrEn && fullWord && (avs_address == OFS_OBKEY);
  wire        hitSts   = wrEn && avs_byteenable[0] && (avs_address == OFS_STS);
  wire        hitCtrl1 = wrEn && avs_byteenable[0] && (avs_address == OFS_CTRL1);
  wire        hitCtrl2 = wrEn && avs_byteenable[0] && (avs_address == OFS_CTRL2);
  wire        hitAddr  = wrEn && (avs_byteenable[1:0] == 2'b11) && (avs_address == OFS_ADDR);
  wire        hitData  = wrEn && (avs_byteenable[1:0] == 2'b11) && (avs_address == OFS_DATA);

  // lock state
  wire unlocked = (mainKey_r == KEY_OPEN);
  wire option_write_enable    = (optKey_r == KEY_OPEN) && unlocked;
  wire cmdOk    = unlocked && idle;

  // protection state taken from the reloaded option bytes
  wire [7:0]  rpByte  = opt_r[7:0];
  wire [31:0] wrpWord = opt_r[63:32];
  wire        lvl0    = (rpByte == RP_LEVEL0);
  wire        lvl2    = (rpByte == RP_LEVEL2);
  wire        lvl1    = !lvl0 && !lvl2;
  wire        mainBlk = lvl2 || (lvl1 && (cpuMode != MODE_USER));
  wire [3:0]  unitSel = addr_r[UNIT_LSB +: 4];
  wire        unitWp  = !wrpWord[unitSel];
  wire        anyWp   = (wrpWord[15:0] != 16'hffff);

  // commands
  wire startProg = hitData && cmdOk && ctrl1_r[C1_PG];
  wire startOpg  = hitData && cmdOk && ctrl1_r[C1_OPG] && option_write_enable;
  wire startStrt = hitCtrl1 && cmdOk && wd[C1_STRT];
  wire doMer     = startStrt && wd[C1_MER];
  wire doPer     = startStrt && wd[C1_PER] && !wd[C1_MER];
  wire doOer     = startStrt && wd[C1_OER] && !wd[C1_MER] && !wd[C1_PER] && option_write_enable;
  wire [7:0] optByte = wd[7:0];
  wire toLevel0  = (addr_r[2:0] == 3'h0) && (optByte == RP_LEVEL0) && lvl1;

  // reload complement check
  wire       cmpOk   = (flashRdata[7:0] == ~flashRdata[15:8]);
  wire [7:0] loadVal = cmpOk ? flashRdata[7:0] : OPT_BAD;

  // key sequencing
  always_comb begin
    mainKey_nxt = mainKey_r;
    optKey_nxt  = optKey_r;
    if (hitKey) begin
      mainKey_nxt = fpp_key_step(mainKey_r, wd);
    end else if (hitCtrl2 && wd[C2_LOCK] && unlocked) begin
      mainKey_nxt = KEY_IDLE;
    end
    if (hitObkey) begin
      optKey_nxt = fpp_key_step(optKey_r, wd);
    end else if (hitCtrl2 && unlocked && !wd[C2_OPTION_WRITE_ENABLE] && (optKey_r == KEY_OPEN)) begin
      optKey_nxt = KEY_IDLE;
    end
  end

  // operation sequencer
  always_comb begin
    state_nxt = state_r;
    req_nxt   = req_r;
    reqV_nxt  = 1'b0;
    pend_nxt  = pend_r;
    idx_nxt   = idx_r;
    setPef    = 1'b0;
    setWpef   = 1'b0;
    setOcf    = 1'b0;
    setObe    = 1'b0;
    optLoad   = 1'b0;
    unique case (state_r)
      ST_LOAD: begin
        req_nxt   = '{op: OP_OPT_READ, addr: {13'h0, idx_r}, data: 16'h0};
        reqV_nxt  = 1'b1;
        state_nxt = ST_LOADW;
      end
      ST_LOADW: begin
        if (flashAck) begin
          optLoad = 1'b1;
          setObe  = !cmpOk;
          idx_nxt = idx_r + 3'h1;
          state_nxt = (idx_r == OPT_LAST) ? ST_IDLE : ST_LOAD;
        end
      end
      ST_IDLE: begin
        if (startProg) begin
          if (mainBlk || unitWp) begin
            setWpef = 1'b1;
          end else begin
            req_nxt   = '{op: OP_READ, addr: addr_r, data: 16'h0};
            reqV_nxt  = 1'b1;
            pend_nxt  = wd[15:0];
            state_nxt = ST_CHECK;
          end
        end else if (startOpg) begin
          pend_nxt = {~optByte, optByte};
          if (lvl2) begin
            setWpef = 1'b1;
          end else if (toLevel0) begin
            req_nxt   = '{op: OP_MASS_ERASE, addr: 16'h0, data: 16'h0};
            reqV_nxt  = 1'b1;
            state_nxt = ST_PRE;
          end else begin
            req_nxt   = '{op: OP_OPT_PROG, addr: {13'h0, addr_r[2:0]}, data: {~optByte, optByte}};
            reqV_nxt  = 1'b1;
            state_nxt = ST_EXEC;
          end
        end else if (doMer) begin
          if (mainBlk || anyWp) begin
            setWpef = 1'b1;
          end else begin
            req_nxt   = '{op: OP_MASS_ERASE, addr: 16'h0, data: 16'h0};
            reqV_nxt  = 1'b1;
            state_nxt = ST_EXEC;
          end
        end else if (doPer) begin
          if (mainBlk || unitWp) begin
            setWpef = 1'b1;
          end else begin
            req_nxt   = '{op: OP_PAGE_ERASE, addr: addr_r, data: 16'h0};
            reqV_nxt  = 1'b1;
            state_nxt = ST_EXEC;
          end
        end else if (doOer) begin
          if (lvl2) begin
            setWpef = 1'b1;
          end else begin
            req_nxt   = '{op: OP_OPT_ERASE, addr: 16'h0, data: 16'h0};
            reqV_nxt  = 1'b1;
            state_nxt = ST_EXEC;
          end
        end
      end
      ST_CHECK: begin
        if (flashAck) begin
          if (flashRdata != ERASED_HW) begin
            setPef    = 1'b1;
            state_nxt = ST_IDLE;
          end else begin
            req_nxt   = '{op: OP_PROG, addr: addr_r, data: pend_r};
            reqV_nxt  = 1'b1;
            state_nxt = ST_EXEC;
          end
        end
      end
      ST_PRE: begin
        if (flashAck) begin
          req_nxt   = '{op: OP_OPT_PROG, addr: {13'h0, addr_r[2:0]}, data: pend_r};
          reqV_nxt  = 1'b1;
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (flashAck) begin
          setOcf    = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // status flags: hardware set wins over software clear
  wire clrPef  = hitSts && wd[STS_PEF];
  wire clrWpef = hitSts && wd[STS_WRPROT_ERROR_FLAG];
  wire clrOcf  = hitSts && wd[STS_OCF];
  wire clrObe  = hitSts && wd[STS_OBE];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ST_LOAD;
      mainKey_r <= KEY_IDLE;
      optKey_r  <= KEY_IDLE;
      req_r     <= '{op: OP_NONE, addr: 16'h0, data: 16'h0};
      reqV_r    <= 1'b0;
      pend_r    <= 16'h0;
      idx_r     <= 3'h0;
    end else begin
      state_r   <= state_nxt;
      mainKey_r <= mainKey_nxt;
      optKey_r  <= optKey_nxt;
      req_r     <= req_nxt;
      reqV_r    <= reqV_nxt;
      pend_r    <= pend_nxt;
      idx_r     <= idx_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_r <= OPT_RST;
    end else if (optLoad) begin
      opt_r[idx_r*8 +: 8] <= loadVal;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pef_r  <= 1'b0;
      wrprot_error_flag_r <= 1'b0;
      ocf_r  <= 1'b0;
      obe_r  <= 1'b0;
    end else begin
      pef_r  <= setPef || (pef_r && !clrPef);
      wrprot_error_flag_r <= setWpef || (wrprot_error_flag_r && !clrWpef);
      ocf_r  <= setOcf || (ocf_r && !clrOcf);
      obe_r  <= setObe || (obe_r && !clrObe);
    end
  end

  // primary control and address registers accept writes only while unlocked and idle; secondary control while unlocked
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_r <= C1_RST;
      op_complete_irq_en_r  <= 1'b0;
      addr_r  <= 16'h0;
    end else begin
      if (hitCtrl1 && cmdOk) begin
        ctrl1_r <= {1'b0, wd[5:0]};
      end
      if (hitCtrl2 && unlocked) begin
        op_complete_irq_en_r <= wd[C2_OP_COMPLETE_IRQ_EN];
      end
      if (hitAddr && cmdOk) begin
        addr_r <= wd[15:0];
      end
    end
  end

  // read path: one wait state, data registered
  wire [31:0] stsWord = {25'h0, obe_r, ocf_r, wrprot_error_flag_r, 1'b0, pef_r, 1'b0, !idle};
  wire [31:0] c2Word  = {29'h0, op_complete_irq_en_r, option_write_enable, !unlocked};
  wire [31:0] rdMux =
    (avs_address == OFS_STS)   ? stsWord :
    (avs_address == OFS_CTRL1) ? {25'h0, ctrl1_r} :
    (avs_address == OFS_CTRL2) ? c2Word :
    (avs_address == OFS_ADDR)  ? {16'h0, addr_r} :
    (avs_address == OFS_OBCS)  ? opt_r[31:0] :
    (avs_address == OFS_WPROT) ? wrpWord : 32'h0;
  wire rdStart = avs_read && !rdDone_r && !loading;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdDone_r <= 1'b0;
      rdata_r  <= 32'h0;
    end else begin
      rdDone_r <= rdStart;
      if (rdStart) begin
        rdata_r <= rdMux;
      end
    end
  end

  assign avs_waitrequest = loading || (avs_read && !rdDone_r);
  assign avs_readdata    = rdata_r;
  assign flashReq        = req_r;
  assign flashReqValid   = reqV_r;
  assign opCompleteIrq   = ocf_r && op_complete_irq_en_r;
  assign mainAccessEn    = !loading && !mainBlk;
  assign debugDeny       = lvl2;
endmodule : fpp_flash_ctrl

// *** verif/flash_program_protect_ctrl_tb_top.sv ***
// testbench: flash controller driven over its register bus against the array model
`timescale 1ns/1ns
`define CHK(got, exp) begin numChecks++; if ((got) !== (exp)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module flash_program_protect_ctrl_tb_top
  import fpp_pkg::*;
;
  localparam logic [15:0] OPT_INIT [8] = '{16'h55aa, 16'h0ff0, 16'h1212, 16'hcb34, 16'h01fe, 16'h00ff, 16'h00ff,
                                           16'h00ff};
  localparam logic [31:0] ERASE_ALL = (32'h1 << C1_MER) | (32'h1 << C1_STRT);
  localparam logic [31:0] ERASE_OPT = (32'h1 << C1_OER) | (32'h1 << C1_STRT);
  logic           core_clk, rst_n, avsRead, avsWrite, avsWaitrequest, flashReqValid, flashAck;
  logic           opCompleteIrq, mainAccessEn, debugDeny;
  logic [3:0]     avsAddress, ackDelay;
  logic [31:0]    avsWritedata, avsReaddata;
  logic [15:0]    flashRdata;
  fpp_mode_t      cpuMode;
  fpp_flash_req_t flashReq;
  int             errors, numChecks, cycles;

  fpp_flash_ctrl dut_u (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avsAddress), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(4'hf), .avs_readdata(avsReaddata),
    .avs_waitrequest(avsWaitrequest), .cpuMode(cpuMode), .flashReq(flashReq), .flashReqValid(flashReqValid),
    .flashAck(flashAck), .flashRdata(flashRdata), .opCompleteIrq(opCompleteIrq), .mainAccessEn(mainAccessEn),
    .debugDeny(debugDeny));
  fpp_flash_model flash_u (.core_clk(core_clk), .flashReq(flashReq), .flashReqValid(flashReqValid),
    .ackDelay(ackDelay), .flashAck(flashAck), .flashRdata(flashRdata));

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end

  task automatic busWrite(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= 1'b1;
    @(posedge core_clk);
    while (avsWaitrequest !== 1'b0) @(posedge core_clk);
    avsWrite <= 1'b0;
  endtask : busWrite
  task automatic busRead(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    avsAddress <= a;
    avsRead <= 1'b1;
    @(posedge core_clk);
    while (avsWaitrequest !== 1'b0) @(posedge core_clk);
    d = avsReaddata;
    avsRead <= 1'b0;
  endtask : busRead
  task automatic chkReg(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    busRead(a, d);
    `CHK(d, e)
  endtask : chkReg
  task automatic waitIdle();
    logic [31:0] d;
    do busRead(OFS_STS, d); while (d[STS_BUSY] !== 1'b0);
  endtask : waitIdle
  task automatic prog(input logic [15:0] a, input logic [15:0] d);
    busWrite(OFS_ADDR, {16'h0000, a});
    busWrite(OFS_DATA, {16'h0000, d});
    waitIdle();
  endtask : prog
  task automatic unlock(input logic [3:0] a);
    busWrite(a, UNLOCK_KEY_FIRST);
    busWrite(a, UNLOCK_KEY_SECOND);
  endtask : unlock

  task automatic t_reload_lock();
    chkReg(OFS_OBCS, 32'h34fff0aa);
    chkReg(OFS_WPROT, 32'hfffffffe);
    chkReg(OFS_STS, 32'h1 << STS_OBE);
    `CHK(mainAccessEn, 1'b1)
    `CHK(debugDeny, 1'b0)
    chkReg(OFS_CTRL2, 32'h1);
    busWrite(OFS_CTRL1, 32'h1 << C1_PG);
    chkReg(OFS_CTRL1, 32'h0);
    chkReg(4'hf, 32'h0);
    $display("test reload_lock done");
  endtask : t_reload_lock
  task automatic t_program();
    ackDelay <= 4'h5;
    unlock(OFS_KEY);
    chkReg(OFS_CTRL2, 32'h0);
    busWrite(OFS_STS, 32'h74);
    busWrite(OFS_CTRL1, 32'h1 << C1_PG);
    prog(16'h1002, 16'h1234);
    chkReg(OFS_STS, 32'h1 << STS_OCF);
    `CHK(flash_u.mainMem[16'h0801], 16'h1234)
    busWrite(OFS_STS, 32'h74);
    prog(16'h1002, 16'h0000);
    chkReg(OFS_STS, 32'h1 << STS_PEF);
    busWrite(OFS_STS, 32'h74);
    prog(16'h0ffe, 16'h0000);
    chkReg(OFS_STS, 32'h1 << STS_WRPROT_ERROR_FLAG);
    `CHK(flash_u.mainMem[16'h07ff], ERASED_HW)
    busWrite(OFS_STS, 32'h74);
    busWrite(OFS_CTRL1, ERASE_ALL);
    waitIdle();
    chkReg(OFS_STS, 32'h1 << STS_WRPROT_ERROR_FLAG);
    `CHK(flash_u.mainMem[16'h0801], 16'h1234)
    busWrite(OFS_STS, 32'h74);
    busWrite(OFS_CTRL2, 32'h1 << C2_OP_COMPLETE_IRQ_EN);
    busWrite(OFS_CTRL1, 32'h1 << C1_PG);
    ackDelay <= 4'h0;
    prog(16'h1004, 16'hbeef);
    `CHK(opCompleteIrq, 1'b1)
    busWrite(OFS_STS, 32'h74);
    @(posedge core_clk);
    `CHK(opCompleteIrq, 1'b0)
    $display("test program done");
  endtask : t_program
  task automatic t_options();
    unlock(OFS_OBKEY);
    chkReg(OFS_CTRL2, (32'h1 << C2_OPTION_WRITE_ENABLE) | (32'h1 << C2_OP_COMPLETE_IRQ_EN));
    busWrite(OFS_CTRL1, ERASE_OPT);
    waitIdle();
    chkReg(OFS_STS, 32'h1 << STS_OCF);
    `CHK(flash_u.optMem[3], 16'hffff)
    busWrite(OFS_CTRL1, 32'h1 << C1_OPG);
    prog(16'h0003, 16'h005a);
    `CHK(flash_u.optMem[3], 16'ha55a)
    chkReg(OFS_OBCS, 32'h34fff0aa);
    busWrite(OFS_CTRL2, 32'h0);
    busWrite(OFS_CTRL1, ERASE_OPT);
    waitIdle();
    `CHK(flash_u.optMem[3], 16'ha55a)
    busWrite(OFS_CTRL1, 32'h0);
    busWrite(OFS_CTRL2, 32'h1 << C2_LOCK);
    chkReg(OFS_CTRL2, 32'h1);
    busWrite(OFS_CTRL1, 32'h1 << C1_PG);
    chkReg(OFS_CTRL1, 32'h0);
    $display("test options done");
  endtask : t_options
  task automatic t_level1();
    chkReg(OFS_OBCS, 32'h5affffff);
    chkReg(OFS_WPROT, 32'hffffffff);
    chkReg(OFS_STS, 32'h1 << STS_OBE);
    chkReg(OFS_CTRL2, 32'h1);
    unlock(OFS_KEY);
    busWrite(OFS_STS, 32'h74);
    busWrite(OFS_CTRL1, ERASE_ALL);
    waitIdle();
    chkReg(OFS_STS, 32'h1 << STS_OCF);
    `CHK(flash_u.mainMem[16'h0801], ERASED_HW)
    busWrite(OFS_CTRL1, 32'h1 << C1_PG);
    prog(16'h3000, 16'h1111);
    `CHK(flash_u.mainMem[16'h1800], 16'h1111)
    busWrite(OFS_STS, 32'h74);
    cpuMode <= MODE_DEBUG;
    busWrite(OFS_CTRL1, 32'h1 << C1_PG);
    `CHK(mainAccessEn, 1'b0)
    prog(16'h2000, 16'h0000);
    chkReg(OFS_STS, 32'h1 << STS_WRPROT_ERROR_FLAG);
    `CHK(flash_u.mainMem[16'h1000], ERASED_HW)
    busWrite(OFS_STS, 32'h74);
    unlock(OFS_OBKEY);
    busWrite(OFS_CTRL1, 32'h1 << C1_OPG);
    prog(16'h0000, 16'h00aa);
    `CHK(flash_u.mainMem[16'h1800], ERASED_HW)
    `CHK(flash_u.optMem[0], 16'h55aa)
    chkReg(OFS_STS, 32'h1 << STS_OCF);
    cpuMode <= MODE_USER;
    busWrite(OFS_CTRL1, 32'h0);
    busWrite(OFS_CTRL2, 32'h1 << C2_LOCK);
    busWrite(OFS_KEY, UNLOCK_KEY_SECOND);
    unlock(OFS_KEY);
    unlock(OFS_OBKEY);
    chkReg(OFS_CTRL2, 32'h1);
    busWrite(OFS_CTRL1, 32'h1 << C1_PG);
    chkReg(OFS_CTRL1, 32'h0);
    $display("test level1_badkey done");
  endtask : t_level1
  task automatic t_level2();
    chkReg(OFS_OBCS, 32'h5affffcc);
    `CHK(debugDeny, 1'b1)
    `CHK(mainAccessEn, 1'b0)
    unlock(OFS_KEY);
    unlock(OFS_OBKEY);
    busWrite(OFS_STS, 32'h74);
    busWrite(OFS_CTRL1, ERASE_ALL);
    waitIdle();
    chkReg(OFS_STS, 32'h1 << STS_WRPROT_ERROR_FLAG);
    busWrite(OFS_STS, 32'h74);
    busWrite(OFS_CTRL1, 32'h1 << C1_OPG);
    prog(16'h0000, 16'h00aa);
    chkReg(OFS_STS, 32'h1 << STS_WRPROT_ERROR_FLAG);
    `CHK(flash_u.optMem[0], 16'h33cc)
    $display("test level2 done");
  endtask : t_level2
  task automatic complete_run();
    $display("checks=%0d errors=%0d", numChecks, errors);
    if (errors == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    errors = 0;
    numChecks = 0;
    cycles = 0;
    core_clk = 1'b0;
    rst_n = 1'b0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsAddress = 4'h0;
    avsWritedata = 32'h0;
    cpuMode = MODE_USER;
    ackDelay = 4'h2;
    for (int i = 0; i < 8; i++) flash_u.optMem[i] = OPT_INIT[i];
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reload_lock();
    t_program();
    t_options();
    rst_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    t_level1();
    flash_u.optMem[0] = 16'h33cc;
    rst_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    t_level2();
    complete_run();
  end
endmodule : flash_program_protect_ctrl_tb_top

// *** verif/fpp_flash_ctrl_properties.sv ***
// checker: port-level properties of the flash controller
`timescale 1ns/1ns
module fpp_flash_ctrl_properties
  import fpp_pkg::*;
(
  input wire logic           core_clk,
  input wire logic           rst_n,
  input wire logic           avs_read,
  input wire logic           avs_write,
  input wire logic           avs_waitrequest,
  input wire fpp_flash_req_t flashReq,
  input wire logic           flashReqValid,
  input wire logic           flashAck,
  input wire logic           opCompleteIrq,
  input wire logic           mainAccessEn,
  input wire logic           debugDeny
);
  logic           pending_r;
  logic [3:0]     ackCnt_r;
  fpp_flash_req_t lastReq_r;
  // one request outstanding, acks counted up to the end of the reload
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_r <= 1'b0;
      ackCnt_r  <= 4'h0;
      lastReq_r <= '0;
    end else begin
      pending_r <= flashReqValid | (pending_r & ~flashAck);
      if (flashReqValid) lastReq_r <= flashReq;
      if (flashAck && ackCnt_r != 4'h8) ackCnt_r <= ackCnt_r + 4'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_req_pulse: assert property (flashReqValid |=> !flashReqValid) else $error("request valid longer than one cycle");
  a_one_pending: assert property (flashReqValid |-> !pending_r) else $error("new request before ack");
  a_req_hold: assert property (!flashReqValid |-> $stable(flashReq)) else $error("request moved between pulses");
  a_reload_order: assert property (flashReqValid && ackCnt_r < 4'h8 |-> flashReq.op == OP_OPT_READ
    && flashReq.addr == {13'h0000, ackCnt_r[2:0]}) else $error("reload request out of order");
  a_stall_load: assert property ((avs_read || avs_write) && ackCnt_r < 4'h8 |-> avs_waitrequest)
    else $error("bus access taken during reload");
  a_main_load: assert property (ackCnt_r < 4'h8 |-> !mainAccessEn) else $error("main access during reload");
  a_read_wait: assert property (avs_read && avs_waitrequest && ackCnt_r == 4'h8 |=> !avs_waitrequest)
    else $error("read answer late");
  a_prog_check: assert property (flashReqValid && flashReq.op == OP_PROG |-> lastReq_r.op == OP_READ
    && lastReq_r.addr == flashReq.addr) else $error("program without erased check");
  a_deny_main: assert property (debugDeny |-> !mainAccessEn) else $error("main access at top level");
  a_irq_cause: assert property ($rose(opCompleteIrq) |-> $past(flashAck) || $past(avs_write))
    else $error("irq without completion");
endmodule : fpp_flash_ctrl_properties

bind fpp_flash_ctrl fpp_flash_ctrl_properties props_u (.core_clk(core_clk), .rst_n(rst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .flashReq(flashReq), .flashReqValid(flashReqValid),
  .flashAck(flashAck), .opCompleteIrq(opCompleteIrq), .mainAccessEn(mainAccessEn), .debugDeny(debugDeny));

// *** verif/fpp_flash_model.sv ***
// flash array model: main half-words and option pairs, ack after a settable delay
`timescale 1ns/1ns
module fpp_flash_model
  import fpp_pkg::*;
(
  input  wire logic           core_clk,
  input  wire fpp_flash_req_t flashReq,
  input  wire logic           flashReqValid,
  input  wire logic [3:0]     ackDelay,
  output logic                flashAck,
  output logic      [15:0]    flashRdata
);
  logic [15:0]    mainMem [0:32767];
  logic [15:0]    optMem [0:7];
  fpp_flash_req_t req;
  int             cnt;
  initial begin
    flashAck = 1'b0;
    flashRdata = 16'h0000;
    cnt = -1;
    for (int i = 0; i < 32768; i++) mainMem[i] = ERASED_HW;
  end
  always @(posedge core_clk) begin
    flashAck <= 1'b0;
    flashRdata <= ~flashRdata;
    if (flashReqValid) begin
      req = flashReq;
      cnt = ackDelay;
    end else if (cnt == 0) begin
      cnt = -1;
      flashAck <= 1'b1;
      case (req.op)
        OP_READ: flashRdata <= mainMem[req.addr[15:1]];
        OP_OPT_READ: flashRdata <= optMem[req.addr[2:0]];
        OP_PROG: mainMem[req.addr[15:1]] = mainMem[req.addr[15:1]] & req.data;
        OP_MASS_ERASE: for (int i = 0; i < 32768; i++) mainMem[i] = ERASED_HW;
        OP_OPT_PROG: optMem[req.addr[2:0]] = optMem[req.addr[2:0]] & req.data;
        OP_OPT_ERASE: for (int i = 0; i < 8; i++) optMem[i] = 16'hffff;
        default: ;
      endcase
    end else if (cnt > 0) begin
      cnt = cnt - 1;
    end
  end
endmodule : fpp_flash_model
